/* shared/csrc_pkg.sv */
// constants and types shared by the converter sync and range control block
package csrc_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam int FRAME_BITS = 24;
	localparam logic [ADDR_W-1:0] ADDR_MAIN_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_FSR_I = 4'h3;
	localparam logic [ADDR_W-1:0] ADDR_FSR_Q = 4'hB;
	localparam logic [ADDR_W-1:0] ADDR_SYNC_CTRL = 4'hE;
	localparam logic [ADDR_W-1:0] ADDR_FIXED_RO = 4'hF;
	localparam logic [DATA_W-1:0] MAIN_CTRL_RST = 16'h0080;
	localparam logic [DATA_W-1:0] FSR_RST = 16'h4000;
	localparam logic [DATA_W-1:0] SYNC_CTRL_RST = 16'h0003;
	localparam logic [DATA_W-1:0] FIXED_RO_VAL = 16'h001D;
	localparam int DRC_LSB = 7;
	localparam int DRC_W = 9;
	localparam int DCK_BIT = 6;
	localparam int SP_LSB = 3;
	localparam int ES_BIT = 2;
	localparam int DOC_BIT = 1;
	localparam int DR_BIT = 0;
	localparam int MODE_LSB = 5;
	localparam int FSR_W = 15;
	localparam logic [2:0] MODE_CODE_QUAD = 3'h0;
	localparam logic [2:0] MODE_CODE_I = 3'h1;
	localparam logic [2:0] MODE_CODE_Q = 3'h2;
	localparam logic [2:0] MODE_CODE_BOTH = 3'h3;
	localparam logic [DRC_W-1:0] DRC_FULL_CODE = 9'h13F;
	localparam logic [10:0] DELAY_MAX_PS = 11'h4B0;
	localparam int RAW_W = 14;
	localparam int RES_W = 12;
	localparam logic [RES_W-1:0] RES_MAX = 12'hFFF;
	localparam logic [FSR_W-1:0] FSR_PIN_HIGH = 15'h7FFF;
	localparam logic [FSR_W-1:0] FSR_PIN_LOW = 15'h4000;
	localparam int LAT_DIRECT = 5;
	localparam int LAT_DEMUX = 6;
	localparam int OUT_DELAY_CYC = 1;
	typedef enum logic [2:0] {
		SAMP_SINGLE_EDGE,
		SAMP_DUAL_I,
		SAMP_DUAL_Q,
		SAMP_DUAL_BOTH,
		SAMP_DUAL_QUAD
	} csrc_samp_t;
endpackage : csrc_pkg

/* shared/csrc_reg_if.sv */
// register access carrier between the serial slave and the register file
`timescale 1ns/10ps
`default_nettype none
interface csrc_reg_if;
	logic wr_stb;
	logic [3:0] addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	modport slave(output wr_stb, output addr, output wdata, input rdata);
	modport regs(input wr_stb, input addr, input wdata, output rdata);
endinterface : csrc_reg_if
`default_nettype wire

/* core/csrc_serial_slave.sv */
// serial configuration port: 24-bit frames, rw bit first, msb first
`timescale 1ns/10ps
`default_nettype none
module csrc_serial_slave import csrc_pkg::*; (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic scs_n_in,
	input wire logic sclk_in,
	input wire logic sdi_in,
	output logic sdo_out,
	csrc_reg_if.slave bus
);
	logic sclk_q;
	logic [4:0] cnt_q;
	logic [23:0] sh_q;
	logic rd_q;
	logic [ADDR_W-1:0] addr_q;
	logic [DATA_W-1:0] out_q;
	logic wr_q;
	logic [DATA_W-1:0] wdata_q;
	logic rise;
	logic fall;
	assign rise = sclk_in & ~sclk_q;
	assign fall = ~sclk_in & sclk_q;
	assign bus.addr = addr_q;
	assign bus.wr_stb = wr_q;
	assign bus.wdata = wdata_q;
	assign sdo_out = out_q[DATA_W-1];
	always_ff @(posedge clk_in) begin
		sclk_q <= rst_in ? 1'b0 : sclk_in;
	end
	always_ff @(posedge clk_in) begin
		if (rst_in || scs_n_in) begin
			cnt_q <= 5'h00;
			sh_q <= 24'h000000;
		end else if (rise) begin
			sh_q <= {sh_q[22:0], sdi_in};
			cnt_q <= cnt_q + 5'h01;
		end
	end
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			rd_q <= 1'b0;
			addr_q <= 4'h0;
		end else if (!scs_n_in && rise && cnt_q == 5'h07) begin
			rd_q <= sh_q[6];
			addr_q <= {sh_q[2:0], sdi_in};
		end
	end
	// a frame cut short by chip select never writes
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			wr_q <= 1'b0;
			wdata_q <= 16'h0000;
		end else begin
			wr_q <= !scs_n_in && rise && cnt_q == 5'h17 && !rd_q;
			if (!scs_n_in && rise && cnt_q == 5'h17)
				wdata_q <= {sh_q[14:0], sdi_in};
		end
	end
	always_ff @(posedge clk_in) begin
		if (rst_in || scs_n_in)
			out_q <= 16'h0000;
		else if (fall && cnt_q == 5'h08 && rd_q)
			out_q <= bus.rdata;
		else if (fall && cnt_q > 5'h08)
			out_q <= {out_q[DATA_W-2:0], 1'b0};
	end
	property p_wr_once;
		@(posedge clk_in) disable iff (rst_in) wr_q |=> !wr_q;
	endproperty
	a_wr_once: assert property (p_wr_once) else $error("write strobe longer than one cycle");
	c_write: cover property (@(posedge clk_in) disable iff (rst_in) wr_q);
endmodule : csrc_serial_slave
`default_nettype wire

/* core/csrc_latency_pipe.sv */
// fixed-latency result pipeline with two selectable depths
`timescale 1ns/10ps
`default_nettype none
module csrc_latency_pipe #(
	parameter int W = 13,
	parameter int SHORT = 6,
	parameter int LONG = 7
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic long_in,
	input wire logic [W-1:0] din_in,
	output logic [W-1:0] dout_out
);
	logic [W-1:0] st_q [LONG-1];
	logic [W-1:0] out_q;
	logic [3:0] stable_q;
	initial begin
		if (SHORT < 2 || LONG < SHORT || LONG > 15)
			$error("latency depths out of range");
	end
	assign dout_out = out_q;
	always_ff @(posedge clk_in) begin
		st_q[0] <= rst_in ? '0 : din_in;
		for (int k = 1; k < LONG - 1; k++)
			st_q[k] <= rst_in ? '0 : st_q[k-1];
	end
	always_ff @(posedge clk_in) begin
		if (rst_in)
			out_q <= '0;
		else
			out_q <= long_in ? st_q[LONG-2] : st_q[SHORT-2];
	end
	always_ff @(posedge clk_in) begin
		if (rst_in || long_in != $past(long_in))
			stable_q <= 4'h0;
		else if (stable_q != 4'hF)
			stable_q <= stable_q + 4'h1;
	end
	property p_short_lat;
		@(posedge clk_in) disable iff (rst_in)
		(stable_q >= 4'(LONG)) && !long_in |-> dout_out == $past(din_in, SHORT);
	endproperty
	a_short_lat: assert property (p_short_lat) else $error("short latency mismatch");
endmodule : csrc_latency_pipe
`default_nettype wire

/* core/csrc_top.sv */
// sync, sampling edge, latency, clipping and range control of a dual converter
// Functional notes
// - nine-bit code delays reference clock, 0-1200 ps
// - codes past full code hold maximum delay
// - bit 6 plus mode 000 gives quadrature dual-edge
// - two bits pick latched reference clock phase
// - bit 2 set makes follower, else master
// - bit 1 low drives quarter-rate reference outputs
// - bit 0 low enables output clock realign input
// - top register reads fixed pattern, ignores writes
// - conversion runs continuously, no start command
// - single-edge: both channels sample rising edge
// - dual-edge: first rising, second falling edge
// - results appear after mode-dependent fixed latency
// - dual-edge input: first, second, or both
// - twelve-bit results clip to all ones/zeros
// - per-channel flag while result out of span
// - full scale from pin, or per-channel fields
`timescale 1ns/10ps
`default_nettype none
module csrc_top import csrc_pkg::*; #(
	parameter int LAT_DIRECT_CYC = LAT_DIRECT,
	parameter int LAT_DEMUX_CYC = LAT_DEMUX
) (
	input wire logic CLOCK_IN,
	input wire logic RESET_IN,
	input wire logic SCS_N_IN,
	input wire logic SCLK_IN,
	input wire logic SDI_IN,
	output logic SDO_OUT,
	input wire logic REF_CLOCK_IN,
	input wire logic OUTPUT_CLOCK_REALIGN_IN,
	input wire logic FULL_SCALE_RANGE_SELECT_IN,
	input wire logic EXTENDED_CONTROL_MODE_IN,
	input wire logic DEMUX_IN,
	input wire logic signed [RAW_W-1:0] I_ACCURATE_IN,
	input wire logic signed [RAW_W-1:0] Q_ACCURATE_IN,
	output logic REF_CLOCK_OUT_A,
	output logic REF_CLOCK_OUT_B,
	output logic [10:0] REF_DELAY_PS_OUT,
	output logic [1:0] REF_LATCH_PHASE_OUT,
	output logic FOLLOWER_SYNC_ENABLE_OUT,
	output logic DATA_CLOCK_OUT,
	output logic DUAL_EDGE_OUT,
	output logic I_SAMPLE_FALL_OUT,
	output logic Q_SAMPLE_FALL_OUT,
	output logic [RES_W-1:0] I_DATA_OUT,
	output logic [RES_W-1:0] Q_DATA_OUT,
	output logic RANGE_FLAG_I_OUT,
	output logic RANGE_FLAG_Q_OUT,
	output logic [FSR_W-1:0] FULL_SCALE_I_OUT,
	output logic [FSR_W-1:0] FULL_SCALE_Q_OUT
);
	initial begin
		if (LAT_DIRECT_CYC < 1 || LAT_DEMUX_CYC < LAT_DIRECT_CYC)
			$error("latency parameters unusable");
	end

	csrc_reg_if reg_bus();

	csrc_serial_slave u_serial (
		.clk_in(CLOCK_IN),
		.rst_in(RESET_IN),
		.scs_n_in(SCS_N_IN),
		.sclk_in(SCLK_IN),
		.sdi_in(SDI_IN),
		.sdo_out(SDO_OUT),
		.bus(reg_bus.slave)
	);

	// register file
	logic [DATA_W-1:0] main_ctrl_q;
	logic [DATA_W-1:0] fsr_i_q;
	logic [DATA_W-1:0] fsr_q_q;
	logic [DATA_W-1:0] sync_ctrl_q;

	always_ff @(posedge CLOCK_IN) begin
		if (RESET_IN)
			sync_ctrl_q <= SYNC_CTRL_RST;
		else if (reg_bus.wr_stb && reg_bus.addr == ADDR_SYNC_CTRL)
			sync_ctrl_q <= reg_bus.wdata;
	end

	always_ff @(posedge CLOCK_IN) begin
		if (RESET_IN)
			main_ctrl_q <= MAIN_CTRL_RST;
		else if (reg_bus.wr_stb && reg_bus.addr == ADDR_MAIN_CTRL)
			main_ctrl_q <= reg_bus.wdata;
	end

	always_ff @(posedge CLOCK_IN) begin
		if (RESET_IN) begin
			fsr_i_q <= FSR_RST;
			fsr_q_q <= FSR_RST;
		end else if (reg_bus.wr_stb) begin
			if (reg_bus.addr == ADDR_FSR_I)
				fsr_i_q <= {1'b0, reg_bus.wdata[FSR_W-1:0]};
			if (reg_bus.addr == ADDR_FSR_Q)
				fsr_q_q <= {1'b0, reg_bus.wdata[FSR_W-1:0]};
		end
	end

	// the fixed word has no storage, so a write to it lands nowhere
	always_comb begin
		case (reg_bus.addr)
			ADDR_MAIN_CTRL: reg_bus.rdata = main_ctrl_q;
			ADDR_FSR_I: reg_bus.rdata = fsr_i_q;
			ADDR_FSR_Q: reg_bus.rdata = fsr_q_q;
			ADDR_SYNC_CTRL: reg_bus.rdata = sync_ctrl_q;
			ADDR_FIXED_RO: reg_bus.rdata = FIXED_RO_VAL;
			default: reg_bus.rdata = 16'h0000;
		endcase
	end

	// field views
	logic [DRC_W-1:0] ref_clock_delay_code;
	logic dual_edge_quadrature_enable;
	logic [1:0] ref_latch_phase;
	logic follower_sync_enable;
	logic ref_out_disable;
	logic output_clock_clear_off;
	logic [2:0] mode_code;

	assign ref_clock_delay_code = sync_ctrl_q[DRC_LSB +: DRC_W];
	assign dual_edge_quadrature_enable = sync_ctrl_q[DCK_BIT];
	assign ref_latch_phase = sync_ctrl_q[SP_LSB +: 2];
	assign follower_sync_enable = sync_ctrl_q[ES_BIT];
	assign ref_out_disable = sync_ctrl_q[DOC_BIT];
	assign output_clock_clear_off = sync_ctrl_q[DR_BIT];
	assign mode_code = main_ctrl_q[MODE_LSB +: 3];

	// reference clock delay, scaled linearly up to the full code
	logic [10:0] delay_ps_q;
	logic [31:0] delay_scaled;
	assign delay_scaled = (32'(ref_clock_delay_code) * 32'(DELAY_MAX_PS)) / 32'(DRC_FULL_CODE);

	always_ff @(posedge CLOCK_IN) begin
		if (RESET_IN)
			delay_ps_q <= 11'h000;
		else if (ref_clock_delay_code >= DRC_FULL_CODE)
			delay_ps_q <= DELAY_MAX_PS;
		else
			delay_ps_q <= delay_scaled[10:0];
	end
	assign REF_DELAY_PS_OUT = delay_ps_q;

	// latch phase and role are published from flops for the analog side
	logic [1:0] phase_q;
	logic follower_q;
	always_ff @(posedge CLOCK_IN) begin
		if (RESET_IN) begin
			phase_q <= 2'h0;
			follower_q <= 1'b0;
		end else begin
			phase_q <= ref_latch_phase;
			follower_q <= follower_sync_enable;
		end
	end
	assign REF_LATCH_PHASE_OUT = phase_q;
	assign FOLLOWER_SYNC_ENABLE_OUT = follower_q;

	// quarter-rate divider; a follower realigns it to the master's reference
	logic ref_in_q;
	logic ref_rise;
	logic [1:0] div_q;
	assign ref_rise = REF_CLOCK_IN & ~ref_in_q;

	always_ff @(posedge CLOCK_IN) begin
		ref_in_q <= RESET_IN ? 1'b0 : REF_CLOCK_IN;
	end

	always_ff @(posedge CLOCK_IN) begin
		if (RESET_IN)
			div_q <= 2'h0;
		else if (follower_sync_enable && ref_rise)
			div_q <= ref_latch_phase;
		else
			div_q <= div_q + 2'h1;
	end

	// both outputs stay off while disabled, in either role
	logic ref_out_a_q;
	logic ref_out_b_q;
	always_ff @(posedge CLOCK_IN) begin
		if (RESET_IN) begin
			ref_out_a_q <= 1'b0;
			ref_out_b_q <= 1'b0;
		end else begin
			ref_out_a_q <= !ref_out_disable && div_q[1];
			ref_out_b_q <= !ref_out_disable && div_q[1];
		end
	end
	assign REF_CLOCK_OUT_A = ref_out_a_q;
	assign REF_CLOCK_OUT_B = ref_out_b_q;

	// output data clock, half rate; realign pulls it low when allowed
	logic dclk_q;
	always_ff @(posedge CLOCK_IN) begin
		if (RESET_IN)
			dclk_q <= 1'b0;
		else if (!output_clock_clear_off && OUTPUT_CLOCK_REALIGN_IN)
			dclk_q <= 1'b0;
		else
			dclk_q <= !dclk_q;
	end
	assign DATA_CLOCK_OUT = dclk_q;

	// sampling mode decode
	csrc_samp_t samp_mode;
	always_comb begin
		case (mode_code)
			MODE_CODE_QUAD: samp_mode = dual_edge_quadrature_enable ? SAMP_DUAL_QUAD : SAMP_SINGLE_EDGE;
			MODE_CODE_I: samp_mode = SAMP_DUAL_I;
			MODE_CODE_Q: samp_mode = SAMP_DUAL_Q;
			MODE_CODE_BOTH: samp_mode = SAMP_DUAL_BOTH;
			default: samp_mode = SAMP_SINGLE_EDGE;
		endcase
	end

	logic dual_q;
	logic i_fall_q;
	logic q_fall_q;
	always_ff @(posedge CLOCK_IN) begin
		if (RESET_IN) begin
			dual_q <= 1'b0;
			i_fall_q <= 1'b0;
			q_fall_q <= 1'b0;
		end else begin
			dual_q <= samp_mode != SAMP_SINGLE_EDGE;
			i_fall_q <= 1'b0;
			q_fall_q <= samp_mode != SAMP_SINGLE_EDGE;
		end
	end
	assign DUAL_EDGE_OUT = dual_q;
	assign I_SAMPLE_FALL_OUT = i_fall_q;
	assign Q_SAMPLE_FALL_OUT = q_fall_q;

	// input choice: one input feeds both phases only in the first-only and second-only dual-edge modes
	logic signed [RAW_W-1:0] i_src;
	logic signed [RAW_W-1:0] q_src;
	always_comb begin
		case (samp_mode)
			SAMP_DUAL_I: begin
				i_src = I_ACCURATE_IN;
				q_src = I_ACCURATE_IN;
			end
			SAMP_DUAL_Q: begin
				i_src = Q_ACCURATE_IN;
				q_src = Q_ACCURATE_IN;
			end
			default: begin
				i_src = I_ACCURATE_IN;
				q_src = Q_ACCURATE_IN;
			end
		endcase
	end

	// clip with flag in bit 12 so the flag travels with its own result
	function automatic logic [RES_W:0] clip_result(input logic signed [RAW_W-1:0] v);
		if (v < 0)
			return {1'b1, {RES_W{1'b0}}};
		else if (v > $signed({2'b00, RES_MAX}))
			return {1'b1, RES_MAX};
		else
			return {1'b0, v[RES_W-1:0]};
	endfunction : clip_result

	logic [RES_W:0] i_pipe_out;
	logic [RES_W:0] q_pipe_out;

	csrc_latency_pipe #(
		.W(RES_W + 1),
		.SHORT(LAT_DIRECT_CYC + OUT_DELAY_CYC),
		.LONG(LAT_DEMUX_CYC + OUT_DELAY_CYC)
	) u_pipe_i (
		.clk_in(CLOCK_IN),
		.rst_in(RESET_IN),
		.long_in(DEMUX_IN),
		.din_in(clip_result(i_src)),
		.dout_out(i_pipe_out)
	);

	csrc_latency_pipe #(
		.W(RES_W + 1),
		.SHORT(LAT_DIRECT_CYC + OUT_DELAY_CYC),
		.LONG(LAT_DEMUX_CYC + OUT_DELAY_CYC)
	) u_pipe_q (
		.clk_in(CLOCK_IN),
		.rst_in(RESET_IN),
		.long_in(DEMUX_IN),
		.din_in(clip_result(q_src)),
		.dout_out(q_pipe_out)
	);

	assign I_DATA_OUT = i_pipe_out[RES_W-1:0];
	assign Q_DATA_OUT = q_pipe_out[RES_W-1:0];
	assign RANGE_FLAG_I_OUT = i_pipe_out[RES_W];
	assign RANGE_FLAG_Q_OUT = q_pipe_out[RES_W];

	// full scale: pin for both channels unless extended control is on
	logic [FSR_W-1:0] fs_i_q;
	logic [FSR_W-1:0] fs_q_q;
	logic [FSR_W-1:0] fs_pin;
	assign fs_pin = FULL_SCALE_RANGE_SELECT_IN ? FSR_PIN_HIGH : FSR_PIN_LOW;
	always_ff @(posedge CLOCK_IN) begin
		if (RESET_IN) begin
			fs_i_q <= FSR_PIN_LOW;
			fs_q_q <= FSR_PIN_LOW;
		end else if (EXTENDED_CONTROL_MODE_IN) begin
			fs_i_q <= fsr_i_q[FSR_W-1:0];
			fs_q_q <= fsr_q_q[FSR_W-1:0];
		end else begin
			fs_i_q <= fs_pin;
			fs_q_q <= fs_pin;
		end
	end
	assign FULL_SCALE_I_OUT = fs_i_q;
	assign FULL_SCALE_Q_OUT = fs_q_q;

	// checks
	property p_delay_sat;
		@(posedge CLOCK_IN) disable iff (RESET_IN) ref_clock_delay_code >= DRC_FULL_CODE |=> REF_DELAY_PS_OUT == DELAY_MAX_PS;
	endproperty
	a_delay_sat: assert property (p_delay_sat) else $error("delay not held at maximum");

	property p_delay_zero;
		@(posedge CLOCK_IN) disable iff (RESET_IN) ref_clock_delay_code == 9'h000 |=> REF_DELAY_PS_OUT == 11'h000;
	endproperty
	a_delay_zero: assert property (p_delay_zero) else $error("zero code gave nonzero delay");

	property p_quad_mode;
		@(posedge CLOCK_IN) disable iff (RESET_IN) dual_edge_quadrature_enable && mode_code == MODE_CODE_QUAD |=> DUAL_EDGE_OUT;
	endproperty
	a_quad_mode: assert property (p_quad_mode) else $error("quadrature dual-edge not entered");

	property p_follower_align;
		@(posedge CLOCK_IN) disable iff (RESET_IN) follower_sync_enable && ref_rise |=> div_q == $past(ref_latch_phase);
	endproperty
	a_follower_align: assert property (p_follower_align) else $error("follower divider not realigned");

	property p_ref_off;
		@(posedge CLOCK_IN) disable iff (RESET_IN) ref_out_disable ##1 ref_out_disable |-> !REF_CLOCK_OUT_A && !REF_CLOCK_OUT_B;
	endproperty
	a_ref_off: assert property (p_ref_off) else $error("reference outputs driven while disabled");

	property p_realign_ignored;
		@(posedge CLOCK_IN) disable iff (RESET_IN) output_clock_clear_off |=> DATA_CLOCK_OUT != $past(DATA_CLOCK_OUT);
	endproperty
	a_realign_ignored: assert property (p_realign_ignored) else $error("data clock stalled while realign off");

	property p_fixed_word;
		@(posedge CLOCK_IN) disable iff (RESET_IN) reg_bus.wr_stb && reg_bus.addr == ADDR_FIXED_RO
			|=> $stable(sync_ctrl_q) && $stable(main_ctrl_q) && $stable(fsr_i_q) && $stable(fsr_q_q);
	endproperty
	a_fixed_word: assert property (p_fixed_word) else $error("write to fixed word changed a register");

	property p_edges;
		@(posedge CLOCK_IN) disable iff (RESET_IN) !I_SAMPLE_FALL_OUT && (Q_SAMPLE_FALL_OUT == DUAL_EDGE_OUT);
	endproperty
	a_edges: assert property (p_edges) else $error("sampling edge assignment wrong");

	property p_flag_clip;
		@(posedge CLOCK_IN) disable iff (RESET_IN) RANGE_FLAG_I_OUT |-> (I_DATA_OUT == RES_MAX || I_DATA_OUT == 12'h000);
	endproperty
	a_flag_clip: assert property (p_flag_clip) else $error("flagged result not clipped");

	property p_pin_range;
		@(posedge CLOCK_IN) disable iff (RESET_IN) !EXTENDED_CONTROL_MODE_IN |=> FULL_SCALE_I_OUT == FULL_SCALE_Q_OUT;
	endproperty
	a_pin_range: assert property (p_pin_range) else $error("pin range not shared by channels");

	c_dual_quad: cover property (@(posedge CLOCK_IN) disable iff (RESET_IN) samp_mode == SAMP_DUAL_QUAD);
	c_follower: cover property (@(posedge CLOCK_IN) disable iff (RESET_IN) follower_sync_enable && ref_rise);
	c_range_q: cover property (@(posedge CLOCK_IN) disable iff (RESET_IN) RANGE_FLAG_Q_OUT);
	c_realign: cover property (@(posedge CLOCK_IN) disable iff (RESET_IN) !output_clock_clear_off && OUTPUT_CLOCK_REALIGN_IN);
endmodule : csrc_top
`default_nettype wire

/* tb/csrc_ref_peer.sv */
// reference clock source standing in for a master converter on the sync link
`timescale 1ns/10ps
`default_nettype none
module csrc_ref_peer (
	input wire logic clk_in,
	input wire logic run_in,
	output logic ref_clock_out
);
	logic [1:0] div_q;
	// quarter-rate like a master; held low when stopped so no stale level leaks out
	always_ff @(posedge clk_in) begin
		if (!run_in) begin
			div_q <= 2'h0;
		end else begin
			div_q <= div_q + 2'h1;
		end
	end
	assign ref_clock_out = run_in & div_q[1];
endmodule : csrc_ref_peer
`default_nettype wire

/* tb/tb.sv */
// self-checking bench for the converter sync and range control block
`timescale 1ns/10ps
`default_nettype none
module tb;
	import csrc_pkg::*;
	localparam int LAT_S = 5;
	localparam int LAT_L = 6;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic scs_n = 1'b1;
	logic sclk = 1'b0;
	logic sdi = 1'b0;
	logic realign = 1'b0;
	logic fsr_pin = 1'b0;
	logic extended_control_mode = 1'b0;
	logic demux = 1'b0;
	logic peer_run = 1'b0;
	logic signed [RAW_W-1:0] i_acc = 14'sh0100;
	logic signed [RAW_W-1:0] q_acc = 14'sh0100;
	wire logic sdo, ref_in, ref_a, ref_b, follower, dclk, dual, ifall, qfall, iflag, qflag;
	wire logic [10:0] delay;
	wire logic [1:0] phase;
	wire logic [RES_W-1:0] idata, qdata;
	wire logic [FSR_W-1:0] fs_i, fs_q;
	int failures = 0;
	int cmp_count = 0;

	always #4 clk = ~clk;

	csrc_ref_peer peer (.clk_in(clk), .run_in(peer_run), .ref_clock_out(ref_in));

	csrc_top #(.LAT_DIRECT_CYC(LAT_S), .LAT_DEMUX_CYC(LAT_L)) dut (
		.CLOCK_IN(clk), .RESET_IN(rst), .SCS_N_IN(scs_n), .SCLK_IN(sclk), .SDI_IN(sdi), .SDO_OUT(sdo),
		.REF_CLOCK_IN(ref_in), .OUTPUT_CLOCK_REALIGN_IN(realign), .FULL_SCALE_RANGE_SELECT_IN(fsr_pin),
		.EXTENDED_CONTROL_MODE_IN(extended_control_mode), .DEMUX_IN(demux), .I_ACCURATE_IN(i_acc), .Q_ACCURATE_IN(q_acc),
		.REF_CLOCK_OUT_A(ref_a), .REF_CLOCK_OUT_B(ref_b), .REF_DELAY_PS_OUT(delay),
		.REF_LATCH_PHASE_OUT(phase), .FOLLOWER_SYNC_ENABLE_OUT(follower), .DATA_CLOCK_OUT(dclk),
		.DUAL_EDGE_OUT(dual), .I_SAMPLE_FALL_OUT(ifall), .Q_SAMPLE_FALL_OUT(qfall), .I_DATA_OUT(idata),
		.Q_DATA_OUT(qdata), .RANGE_FLAG_I_OUT(iflag), .RANGE_FLAG_Q_OUT(qflag),
		.FULL_SCALE_I_OUT(fs_i), .FULL_SCALE_Q_OUT(fs_q)
	);

	task automatic results();
		$display("failures=%0d comparisons=%0d", failures, cmp_count);
		if (failures == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : results

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc

	// one 24-bit frame; sclk held 2 cycles per level, read bits taken late in the low phase
	task automatic frame(input logic rw, input logic [3:0] a, input logic [15:0] d, output logic [15:0] rd);
		logic [23:0] f;
		f = {rw, 3'h0, a, d};
		rd = 16'h0000;
		@(negedge clk);
		scs_n = 1'b0;
		cyc(1);
		for (int i = 0; i < 24; i++) begin
			sdi = f[23-i];
			sclk = 1'b1;
			cyc(2);
			sclk = 1'b0;
			cyc(2);
			if (i >= 7 && i <= 22) begin
				rd[22-i] = sdo;
			end
		end
		scs_n = 1'b1;
		cyc(4);
	endtask : frame

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		logic [15:0] r;
		frame(1'b0, a, d, r);
	endtask : wr

	task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
		logic [15:0] r;
		frame(1'b1, a, 16'h0000, r);
		chk(r, exp);
	endtask : rdchk

	task automatic t_reset();
		chk({15'h0000, ref_a | ref_b}, 16'h0000);
		chk({1'b0, fs_i}, 16'h4000);
		rdchk(ADDR_SYNC_CTRL, 16'h0003);
		rdchk(ADDR_MAIN_CTRL, 16'h0080);
		rdchk(ADDR_FIXED_RO, 16'h001D);
		wr(ADDR_FIXED_RO, 16'hFFE2);
		rdchk(ADDR_FIXED_RO, 16'h001D);
		rdchk(4'h5, 16'h0000);
	endtask : t_reset

	task automatic t_delay();
		int codes[7] = '{0, 1, 100, 318, 319, 320, 511};
		int e;
		foreach (codes[k]) begin
			wr(ADDR_SYNC_CTRL, {codes[k][8:0], 7'h03});
			e = (codes[k] >= 319) ? 1200 : codes[k] * 1200 / 319;
			chk({5'h00, delay}, e[15:0]);
		end
	endtask : t_delay

	task automatic t_phase_role();
		for (int p = 0; p < 4; p++) begin
			wr(ADDR_SYNC_CTRL, {9'h000, 2'h0, p[1:0], 3'h7});
			chk({14'h0000, phase}, p[15:0]);
			chk({15'h0000, follower}, 16'h0001);
		end
		wr(ADDR_SYNC_CTRL, 16'hFF9F);
		rdchk(ADDR_SYNC_CTRL, 16'hFF9F);
		wr(ADDR_SYNC_CTRL, 16'h0003);
		chk({15'h0000, follower}, 16'h0000);
	endtask : t_phase_role

	task automatic t_refout();
		int n;
		logic prev;
		wr(ADDR_SYNC_CTRL, 16'h0001);
		n = 0;
		prev = ref_a;
		repeat (32) begin
			cyc(1);
			if (ref_a && !prev) begin
				n++;
			end
			prev = ref_a;
			chk({15'h0000, ref_b}, {15'h0000, ref_a});
		end
		chk(n[15:0], 16'h0008);
		wr(ADDR_SYNC_CTRL, 16'h0003);
		repeat (8) begin
			cyc(1);
			chk({15'h0000, ref_a | ref_b}, 16'h0000);
		end
	endtask : t_refout

	task automatic t_realign();
		logic prev;
		realign = 1'b1;
		prev = dclk;
		cyc(1);
		chk({15'h0000, dclk}, {15'h0000, ~prev});
		wr(ADDR_SYNC_CTRL, 16'h0002);
		repeat (4) begin
			cyc(1);
			chk({15'h0000, dclk}, 16'h0000);
		end
		realign = 1'b0;
		cyc(2);
		prev = dclk;
		cyc(1);
		chk({15'h0000, dclk}, {15'h0000, ~prev});
		wr(ADDR_SYNC_CTRL, 16'h0003);
	endtask : t_realign

	task automatic t_modes();
		logic [2:0] md[6] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4};
		logic dk[6] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
		logic ex[6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
		q_acc = 14'sh0200;
		foreach (md[k]) begin
			wr(ADDR_SYNC_CTRL, dk[k] ? 16'h0043 : 16'h0003);
			wr(ADDR_MAIN_CTRL, {8'h00, md[k], 5'h00});
			chk({15'h0000, dual}, {15'h0000, ex[k]});
			chk({15'h0000, qfall}, {15'h0000, ex[k]});
			chk({15'h0000, ifall}, 16'h0000);
			cyc(4);
			chk({4'h0, idata}, (md[k] == 3'h2) ? 16'h0200 : 16'h0100);
			chk({4'h0, qdata}, (md[k] == 3'h1) ? 16'h0100 : 16'h0200);
		end
		q_acc = 14'sh0100;
		wr(ADDR_MAIN_CTRL, 16'h0080);
		wr(ADDR_SYNC_CTRL, 16'h0003);
	endtask : t_modes

	// a one-cycle out-of-range pulse on a steady in-range stream, timed through the pipe
	task automatic t_latency(input logic dm, input int exp);
		int n;
		demux = dm;
		cyc(12);
		i_acc = 14'sh1388;
		q_acc = -14'sh0005;
		n = 0;
		while (n < 20 && idata !== 12'hFFF) begin
			cyc(1);
			n++;
			i_acc = 14'sh0100;
			q_acc = 14'sh0100;
		end
		chk(n[15:0], exp[15:0]);
		chk({3'h0, iflag, idata}, 16'h1FFF);
		chk({3'h0, qflag, qdata}, 16'h1000);
		cyc(1);
		chk({3'h0, iflag, idata}, 16'h0100);
	endtask : t_latency

	task automatic t_clip();
		logic signed [RAW_W-1:0] iv[2] = '{14'sh0FFF, 14'sh1000};
		logic signed [RAW_W-1:0] qv[2] = '{14'sh0000, -14'sh0001};
		foreach (iv[k]) begin
			i_acc = iv[k];
			q_acc = qv[k];
			cyc(10);
			chk({3'h0, iflag, idata}, {3'h0, k[0], 12'hFFF});
			chk({3'h0, qflag, qdata}, {3'h0, k[0], 12'h000});
		end
		i_acc = 14'sh0100;
		q_acc = 14'sh0100;
	endtask : t_clip

	task automatic t_fsr();
		fsr_pin = 1'b1;
		cyc(3);
		chk({1'b0, fs_i}, 16'h7FFF);
		chk({1'b0, fs_q}, 16'h7FFF);
		fsr_pin = 1'b0;
		wr(ADDR_FSR_I, 16'hD555);
		wr(ADDR_FSR_Q, 16'h2AAA);
		chk({1'b0, fs_i}, 16'h4000);
		extended_control_mode = 1'b1;
		cyc(3);
		chk({1'b0, fs_i}, 16'h5555);
		chk({1'b0, fs_q}, 16'h2AAA);
		rdchk(ADDR_FSR_I, 16'h5555);
		extended_control_mode = 1'b0;
		cyc(3);
		chk({1'b0, fs_q}, 16'h4000);
	endtask : t_fsr

	initial begin
		#400000;
		failures++;
		results();
	end

	initial begin
		cyc(3);
		rst = 1'b0;
		peer_run = 1'b1;
		t_reset();
		t_delay();
		t_phase_role();
		t_refout();
		t_realign();
		t_modes();
		t_latency(1'b0, LAT_S + OUT_DELAY_CYC);
		t_latency(1'b1, LAT_L + OUT_DELAY_CYC);
		t_clip();
		t_fsr();
		wr(ADDR_SYNC_CTRL, 16'h0044);
		chk({15'h0000, follower}, 16'h0001);
		rst = 1'b1;
		cyc(3);
		rst = 1'b0;
		cyc(1);
		chk({15'h0000, follower}, 16'h0000);
		rdchk(ADDR_SYNC_CTRL, 16'h0003);
		results();
	end
endmodule : tb
`default_nettype wire
